// *** src/tpu_pkg.sv ***
// How it works
// [R1] Six modes: compare, capture, quadrature, PWM, PRPWM, deadtime
// [R2] Count up, down, or up then down
// [R3] Prescaler divides clock by 1 to 128
// [R4] Period and compare have staged buffer copies
// [R5] Separate underflow, overflow, capture/compare outputs
// [R6] Terminal-count interrupt on wrap past limits
// [R7] Capture/compare interrupt on capture or match
// [R8] PWM modes drive true and complement outputs
// [R9] Five event inputs, selectable source and edge
// [R10] Kill input forces outputs to preset state
// [R11] Counter width 16 or 32 by parameter
// [R12] Dead time delays rising edges of outputs
// [R13] Quadrature phases count up or down
package tpu_pkg;
  localparam int unsigned TPU_WIDTH_DEF = 32;
  localparam int unsigned TPU_NSRC = 4;
  localparam logic [2:0] TPU_PRE_MAX = 3'h7;
  localparam logic [7:0] TPU_DT_RST = 8'h00;
  localparam logic [15:0] TPU_LFSR_SEED = 16'hace1;

  typedef enum logic [2:0] {
    TPU_MODE_CMP = 3'h0,
    TPU_MODE_CAP = 3'h1,
    TPU_MODE_QUAD = 3'h2,
    TPU_MODE_PWM = 3'h3,
    TPU_MODE_PRPWM = 3'h4,
    TPU_MODE_PWMDT = 3'h5
  } tpu_mode_t;

  typedef enum logic [1:0] {
    TPU_DIR_UP = 2'h0,
    TPU_DIR_DOWN = 2'h1,
    TPU_DIR_UPDN = 2'h2
  } tpu_dir_t;

  typedef enum logic [1:0] {
    TPU_EDGE_RISE = 2'h0,
    TPU_EDGE_FALL = 2'h1,
    TPU_EDGE_BOTH = 2'h2,
    TPU_EDGE_LEVEL = 2'h3
  } tpu_edge_t;

  // Event index order on the event buses
  localparam int unsigned TPU_EV_START = 0;
  localparam int unsigned TPU_EV_RELOAD = 1;
  localparam int unsigned TPU_EV_STOP = 2;
  localparam int unsigned TPU_EV_COUNT = 3;
  localparam int unsigned TPU_EV_CAPTURE = 4;
  localparam int unsigned TPU_NEV = 5;
endpackage

// *** src/tpu_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module tpu_timer
  import tpu_pkg::*;
#(
  parameter int unsigned WIDTH = TPU_WIDTH_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Configuration
  input wire tpu_mode_t mode,
  input wire tpu_dir_t dir,
  input wire logic [2:0] prescale,
  input wire logic [7:0] dead_time,
  input wire logic [1:0] kill_level,
  // Staged values and swap request
  input wire logic [WIDTH-1:0] period_buf,
  input wire logic [WIDTH-1:0] compare_buf,
  input wire logic buf_swap,
  // Trigger sources and per-event selection
  input wire logic [TPU_NSRC-1:0] trig_in,
  input wire logic [2*TPU_NEV-1:0] ev_src_sel,
  input wire logic [2*TPU_NEV-1:0] ev_edge_sel,
  // Quadrature phases and kill
  input wire logic quad_a,
  input wire logic quad_b,
  input wire logic kill,
  // Status
  output logic [WIDTH-1:0] count,
  output logic [WIDTH-1:0] capture_val,
  output logic running,
  output logic underflow,
  output logic overflow,
  output logic cc_event,
  output logic irq_tc,
  output logic irq_cc,
  // PWM pins
  output logic pwm_out,
  output logic pwm_out_n
);
  logic [TPU_NSRC-1:0] trig_prev_q;
  logic [TPU_NEV-1:0] ev_hit;
  logic [WIDTH-1:0] count_q, count_d;
  logic [WIDTH-1:0] period_q, compare_q, capture_q;
  logic [7:0] pre_q;
  logic pre_tick;
  logic run_q, down_q, swap_pend_q;
  logic uf_q, of_q, cc_q;
  logic [15:0] lfsr_q;
  logic qa_q, qb_q;
  logic quad_step, quad_up;
  logic raw_pwm, line_q, line_n_q;
  logic [7:0] dt_q;
  logic prev_raw_q;
  logic wrap_up, wrap_dn, match;

  function automatic logic edge_hit(input logic now, input logic prev,
                                    input logic [1:0] sel);
    case (tpu_edge_t'(sel))
      TPU_EDGE_RISE: edge_hit = now & ~prev;
      TPU_EDGE_FALL: edge_hit = ~now & prev;
      TPU_EDGE_BOTH: edge_hit = now ^ prev;
      default: edge_hit = now;
    endcase
  endfunction

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_prev_q <= '0;
    end else begin
      trig_prev_q <= trig_in;
    end
  end

  genvar g;
  generate
    for (g = 0; g < TPU_NEV; g++) begin : g_ev
      logic [1:0] s;
      assign s = ev_src_sel[2*g +: 2];
      assign ev_hit[g] = edge_hit(trig_in[s], trig_prev_q[s],
                                  ev_edge_sel[2*g +: 2]); // [R9]
    end
  endgenerate

  // Prescaler runs free so every divided tick is one clk wide
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 8'h01;
    end
  end
  assign pre_tick = ((pre_q & ((8'h01 << prescale) - 8'h01)) == 8'h00); // [R3]

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      qa_q <= 1'b0;
      qb_q <= 1'b0;
    end else begin
      qa_q <= quad_a;
      qb_q <= quad_b;
    end
  end
  // A step is one phase changing alone; direction from phase order
  assign quad_step = (quad_a ^ qa_q) ^ (quad_b ^ qb_q); // [R13]
  assign quad_up = quad_a ^ qb_q; // [R13]

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_q <= 1'b0;
    end else if (ev_hit[TPU_EV_STOP]) begin
      run_q <= 1'b0;
    end else if (ev_hit[TPU_EV_START] || ev_hit[TPU_EV_RELOAD]) begin
      run_q <= 1'b1;
    end
  end

  logic adv;
  assign adv = run_q && ((mode == TPU_MODE_QUAD) ? quad_step
               : (pre_tick && ev_hit[TPU_EV_COUNT]));
  logic step_up;
  // Fixed directions follow dir at once, so a change never wraps backwards
  assign step_up = (mode == TPU_MODE_QUAD) ? quad_up
                   : (dir == TPU_DIR_UP) ? 1'b1
                   : (dir == TPU_DIR_DOWN) ? 1'b0 : !down_q; // [R2]
  assign wrap_up = adv && step_up && (count_q >= period_q);
  assign wrap_dn = adv && !step_up && (count_q == '0);
  assign match = adv && (count_q == compare_q) &&
                 (mode != TPU_MODE_CAP) && (mode != TPU_MODE_QUAD);

  always_comb begin
    count_d = count_q;
    if (adv) begin
      if (wrap_up) begin
        count_d = (dir == TPU_DIR_UPDN && mode != TPU_MODE_QUAD) ?
                  count_q - 1'b1 : '0; // [R2]
      end else if (wrap_dn) begin
        count_d = (dir == TPU_DIR_UPDN && mode != TPU_MODE_QUAD) ?
                  WIDTH'(1) : period_q; // [R2]
      end else if (step_up) begin
        count_d = count_q + 1'b1;
      end else begin
        count_d = count_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= '0;
      down_q <= 1'b0;
    end else if (ev_hit[TPU_EV_RELOAD]) begin
      count_q <= (dir == TPU_DIR_DOWN) ? period_q : '0;
      down_q <= (dir == TPU_DIR_DOWN);
    end else begin
      count_q <= count_d;
      if (dir != TPU_DIR_UPDN) begin
        down_q <= (dir == TPU_DIR_DOWN); // [R2]
      end else if (wrap_up) begin
        down_q <= 1'b1;
      end else if (wrap_dn) begin
        down_q <= 1'b0;
      end
    end
  end

  // Staged values take effect at a terminal count after a swap request, or every cycle while stopped
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      period_q <= '1;
      compare_q <= '0;
      swap_pend_q <= 1'b0;
    end else begin
      if (wrap_up || wrap_dn || !run_q) begin
        if (swap_pend_q || buf_swap || !run_q) begin
          period_q <= period_buf; // [R4]
          compare_q <= compare_buf; // [R4]
        end
        swap_pend_q <= 1'b0;
      end else if (buf_swap) begin
        swap_pend_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      capture_q <= '0;
    end else if (mode == TPU_MODE_CAP && ev_hit[TPU_EV_CAPTURE]) begin
      capture_q <= count_q; // [R7]
    end
  end

  logic cap_hit;
  assign cap_hit = (mode == TPU_MODE_CAP) && ev_hit[TPU_EV_CAPTURE];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      uf_q <= 1'b0;
      of_q <= 1'b0;
      cc_q <= 1'b0;
    end else begin
      uf_q <= wrap_dn; // [R5]
      of_q <= wrap_up; // [R5]
      cc_q <= match || cap_hit; // [R5] [R7]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lfsr_q <= TPU_LFSR_SEED;
    end else if (adv) begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^
                 lfsr_q[10]};
    end
  end

  logic [WIDTH-1:0] rnd;
  assign rnd = WIDTH'(lfsr_q) & period_q;
  always_comb begin
    case (mode)
      TPU_MODE_PRPWM: raw_pwm = rnd < compare_q; // [R1]
      TPU_MODE_PWM, TPU_MODE_PWMDT: raw_pwm = count_q < compare_q; // [R1]
      default: raw_pwm = 1'b0;
    endcase
  end

  // Dead-time counter restarts on each raw edge, in prescaled ticks
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_raw_q <= 1'b0;
      dt_q <= TPU_DT_RST;
    end else begin
      prev_raw_q <= raw_pwm;
      if (raw_pwm != prev_raw_q) begin
        dt_q <= dead_time; // [R12]
      end else if (pre_tick && dt_q != 8'h00) begin
        dt_q <= dt_q - 8'h01;
      end
    end
  end

  logic pwm_mode, dt_mode;
  assign pwm_mode = (mode == TPU_MODE_PWM) || (mode == TPU_MODE_PRPWM) ||
                    (mode == TPU_MODE_PWMDT);
  assign dt_mode = (mode == TPU_MODE_PWMDT);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_q <= 1'b0;
      line_n_q <= 1'b0;
    end else if (kill) begin
      line_q <= kill_level[0]; // [R10]
      line_n_q <= kill_level[1]; // [R10]
    end else if (!pwm_mode) begin
      line_q <= cc_q;
      line_n_q <= ~cc_q;
    end else if (dt_mode) begin
      // Both lines low until the dead time lapses
      line_q <= prev_raw_q && (dt_q == 8'h00) && raw_pwm; // [R12]
      line_n_q <= !prev_raw_q && (dt_q == 8'h00) && !raw_pwm; // [R12]
    end else begin
      line_q <= raw_pwm;
      line_n_q <= ~raw_pwm; // [R8]
    end
  end

  assign count = count_q;
  assign capture_val = capture_q;
  assign running = run_q;
  assign underflow = uf_q;
  assign overflow = of_q;
  assign cc_event = cc_q;
  assign irq_tc = uf_q || of_q; // [R6]
  assign irq_cc = cc_q; // [R7]
  assign pwm_out = line_q;
  assign pwm_out_n = line_n_q;

  width_ok_a: assert property (@(posedge clk) // [R11]
    WIDTH == 16 || WIDTH == 32) else $error("width must be 16 or 32");

  sequence wrap_s;
    wrap_up || wrap_dn;
  endsequence
  tc_pulse_a: assert property (@(posedge clk) disable iff (!reset_n) // [R6]
    wrap_s |=> irq_tc) else $error("terminal count not flagged");
  ovf_out_a: assert property (@(posedge clk) disable iff (!reset_n) // [R5]
    wrap_up |=> overflow && !underflow) else $error("overflow missing");
  cmp_irq_a: assert property (@(posedge clk) disable iff (!reset_n) // [R7]
    match |=> irq_cc) else $error("compare interrupt missing");
  kill_force_a: assert property (@(posedge clk) disable iff (!reset_n) // [R10]
    kill |=> pwm_out == $past(kill_level[0]))
    else $error("kill did not force output");
  pwm_compl_a: assert property (@(posedge clk) disable iff (!reset_n) // [R8]
    !kill && pwm_mode && !dt_mode |=> pwm_out != pwm_out_n)
    else $error("outputs not complementary");
  dt_overlap_a: assert property (@(posedge clk) disable iff (!reset_n) // [R12]
    $past(!kill && dt_mode) |-> !(pwm_out && pwm_out_n))
    else $error("both outputs high in dead time");
  stop_evt_a: assert property (@(posedge clk) disable iff (!reset_n) // [R9]
    ev_hit[TPU_EV_STOP] |=> !running) else $error("stop ignored");
  cap_store_a: assert property (@(posedge clk) disable iff (!reset_n) // [R7]
    cap_hit |=> capture_val == $past(count_q) ##0 cc_event)
    else $error("capture not stored");
  dn_only_a: assert property (@(posedge clk) disable iff (!reset_n) // [R2]
    dir == TPU_DIR_DOWN && mode != TPU_MODE_QUAD |-> !wrap_up)
    else $error("down count wrapped up");
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench
  import tpu_pkg::*;
;
  localparam int unsigned W = 16;
  logic clk, reset_n, buf_swap, kill, quad_a, quad_b;
  tpu_mode_t mode;
  tpu_dir_t dir;
  logic [2:0] prescale;
  logic [7:0] dead_time;
  logic [1:0] kill_level;
  logic [W-1:0] period_buf, compare_buf, count, capture_val, c0;
  logic [TPU_NSRC-1:0] trig_in;
  logic [2*TPU_NEV-1:0] ev_src_sel, ev_edge_sel;
  logic running, underflow, overflow, cc_event, irq_tc, irq_cc;
  logic pwm_out, pwm_out_n;
  logic [2:0] ev3;
  int err_count = 0;
  int n_compared = 0;
  int n;

  assign ev3 = {cc_event, underflow, overflow};

  tpu_timer #(.WIDTH(W)) u_tpu_timer (
    .clk, .reset_n, .mode, .dir, .prescale, .dead_time, .kill_level,
    .period_buf, .compare_buf, .buf_swap, .trig_in, .ev_src_sel,
    .ev_edge_sel, .quad_a, .quad_b, .kill, .count, .capture_val,
    .running, .underflow, .overflow, .cc_event, .irq_tc, .irq_cc,
    .pwm_out, .pwm_out_n
  );

  tpu_trig_model u_tpu_trig_model (
    .clk, .trig_in, .quad_a, .quad_b, .pwm_out, .pwm_out_n
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // First gap after a change may straddle two settings, so measure three times
  task automatic gap(input int s);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (ev3[s] !== 1'b1 && n < 300);
    repeat (2) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (ev3[s] !== 1'b1 && n < 300);
    end
  endtask

  task automatic pulse(input int i);
    u_tpu_trig_model.set_src(i, 1'b1);
    u_tpu_trig_model.set_src(i, 1'b0);
  endtask

  task automatic restart();
    u_tpu_trig_model.set_src(0, 1'b0);
    u_tpu_trig_model.set_src(0, 1'b1);
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    {buf_swap, kill, kill_level} = '0;
    mode = TPU_MODE_CMP;
    dir = TPU_DIR_UP;
    prescale = 3'h0;
    dead_time = 8'h02;
    period_buf = 16'h0005;
    compare_buf = 16'h0002;
    // Start rise on 0, reload 1, stop 2, count level on 0, capture 3
    ev_src_sel = 10'h324;
    ev_edge_sel = 10'h0c0;
    repeat (5) @(negedge clk);
    check("rst_count", count, 0);
    check("rst_run", running, 0);
    check("rst_pwm", {pwm_out, pwm_out_n}, 0);
    @(posedge clk) reset_n <= 1'b1;
    u_tpu_trig_model.set_src(0, 1'b1);
    repeat (3) @(negedge clk);
    check("started", running, 1);
    for (int p = 0; p < 3; p++) begin
      @(posedge clk) prescale <= 3'(p);
      gap(0);
      check("ovf_gap", n, 6 << p);
    end
    @(posedge clk) begin
      prescale <= 3'h0;
      period_buf <= 16'h0003;
    end
    gap(0);
    check("staged_only", n, 6);
    @(posedge clk) buf_swap <= 1'b1;
    @(posedge clk) buf_swap <= 1'b0;
    gap(0);
    check("swapped", n, 4);
    @(posedge clk) dir <= TPU_DIR_DOWN;
    pulse(1);
    gap(1);
    check("unf_gap", n, 4);
    check("irq_tc", irq_tc, 1);
    @(posedge clk) dir <= TPU_DIR_UP;
    gap(2);
    check("cc_gap", n, 4);
    check("irq_cc", irq_cc, 1);
    @(posedge clk) dir <= TPU_DIR_UPDN;
    gap(0);
    check("updn_gap", n, 6);
    @(posedge clk) dir <= TPU_DIR_UP;
    pulse(2);
    repeat (2) @(negedge clk);
    check("stopped", running, 0);
    c0 = count;
    repeat (5) @(negedge clk);
    check("held", count, c0);
    @(posedge clk) mode <= TPU_MODE_CAP;
    restart();
    pulse(3);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (irq_cc !== 1'b1 && n < 6);
    check("cap_irq", irq_cc, 1);
    check("cap_range", capture_val <= 16'h0003, 1);
    check("cap_val", capture_val, c0);
    @(posedge clk) begin
      kill <= 1'b1;
      kill_level <= 2'b10;
    end
    repeat (3) @(negedge clk);
    check("kill_pins", {pwm_out_n, pwm_out}, 2'b10);
    @(posedge clk) kill <= 1'b0;
    for (int m = 3; m < 5; m++) begin
      @(posedge clk) mode <= tpu_mode_t'(m);
      repeat (10) @(negedge clk) check("cmpl", pwm_out ^ pwm_out_n, 1);
    end
    @(posedge clk) mode <= TPU_MODE_PWMDT;
    repeat (40) @(negedge clk);
    check("overlap", u_tpu_trig_model.overlap, 0);
    pulse(2);
    @(posedge clk) begin
      period_buf <= 16'h0064;
      mode <= TPU_MODE_QUAD;
    end
    restart();
    repeat (2) @(negedge clk);
    c0 = count;
    u_tpu_trig_model.quad_step(1'b1, 1'b0);
    u_tpu_trig_model.quad_step(1'b1, 1'b1);
    check("quad_fwd", count, c0 + 16'h0002);
    u_tpu_trig_model.quad_step(1'b1, 1'b0);
    u_tpu_trig_model.quad_step(1'b0, 1'b0);
    check("quad_back", count, c0);
    give_verdict();
  end

  initial begin
    #160000;
    err_count++;
    give_verdict();
  end
endmodule
`default_nettype wire

// *** verif/tpu_trig_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tpu_trig_model
  import tpu_pkg::*;
(
  // Clock
  input wire logic clk,
  // Sources toward the timer
  output logic [TPU_NSRC-1:0] trig_in,
  output logic quad_a,
  output logic quad_b,
  // Pins from the timer
  input wire logic pwm_out,
  input wire logic pwm_out_n
);
  int overlap = 0;

  initial begin
    trig_in = '0;
    quad_a = 1'b0;
    quad_b = 1'b0;
  end

  // Sources move just after an edge so each level is held a full cycle
  task automatic set_src(input int idx, input logic v);
    @(posedge clk);
    trig_in[idx] <= v;
  endtask

  // One phase changes per step, as a real encoder does
  task automatic quad_step(input logic a, input logic b);
    @(posedge clk);
    quad_a <= a;
    quad_b <= b;
    repeat (2) @(posedge clk);
  endtask

  // Both pins high would short a half bridge
  always @(negedge clk) begin
    if (pwm_out === 1'b1 && pwm_out_n === 1'b1)
      overlap++;
  end
endmodule
`default_nettype wire
